// file: rtl/dcsr_pkg.sv
// Constants for the divider configuration and status register bank.
// Assumes byte-wide registers at byte offsets on the configuration port.
package dcsr_pkg;

   localparam int  ADDR_W = 8;
   localparam int  DATA_W = 8;
   localparam int  LOSS_W = 3;

   // Register offsets
   localparam logic [7:0] FB_DIV_HIGH_BITS_ADDR  = 8'h28;
   localparam logic [7:0] FB_DIV_MID_BYTE_ADDR   = 8'h29;
   localparam logic [7:0] FB_DIV_LOW_BYTE_ADDR   = 8'h2A;
   localparam logic [7:0] IN1_DIV_HIGH_BITS_ADDR = 8'h2B;
   localparam logic [7:0] IN1_DIV_MID_BYTE_ADDR  = 8'h2C;
   localparam logic [7:0] IN1_DIV_LOW_BYTE_ADDR  = 8'h2D;
   localparam logic [7:0] IN2_DIV_HIGH_BITS_ADDR = 8'h2E;
   localparam logic [7:0] IN2_DIV_MID_BYTE_ADDR  = 8'h2F;
   localparam logic [7:0] IN2_DIV_LOW_BYTE_ADDR  = 8'h30;
   localparam logic [7:0] INPUT_RATE_RANGES_ADDR = 8'h37;
   localparam logic [7:0] ACTIVE_INPUT_STAT_ADDR = 8'h80;
   localparam logic [7:0] SIGNAL_LOSS_STAT_ADDR  = 8'h81;
   localparam logic [7:0] SIGNAL_LOSS_FLAG_ADDR  = 8'h83;

   // Reset values
   localparam logic [7:0] FB_DIV_HIGH_BITS_RST  = 8'hC0;
   localparam logic [7:0] FB_DIV_MID_BYTE_RST   = 8'h00;
   localparam logic [7:0] FB_DIV_LOW_BYTE_RST   = 8'hF9;
   localparam logic [7:0] IN1_DIV_HIGH_BITS_RST = 8'h00;
   localparam logic [7:0] IN1_DIV_MID_BYTE_RST  = 8'h00;
   localparam logic [7:0] IN1_DIV_LOW_BYTE_RST  = 8'h09;
   localparam logic [7:0] IN2_DIV_HIGH_BITS_RST = 8'h00;
   localparam logic [7:0] IN2_DIV_MID_BYTE_RST  = 8'h00;
   localparam logic [7:0] IN2_DIV_LOW_BYTE_RST  = 8'h00;
   localparam logic [7:0] INPUT_RATE_RANGES_RST = 8'h00;
   localparam logic [7:0] ACTIVE_INPUT_STAT_RST = 8'h20;
   localparam logic [7:0] SIGNAL_LOSS_STAT_RST  = 8'h00;
   localparam logic [7:0] SIGNAL_LOSS_FLAG_RST  = 8'h00;

   // Writable bit masks with reserved bits read as zero, and the active status bit mask
   localparam logic [7:0] FB_DIV_HIGH_BITS_MASK = 8'hEF;
   localparam logic [7:0] DIV_HIGH_BITS_MASK    = 8'h07;
   localparam logic [7:0] RATE_RANGES_MASK      = 8'h3F;
   localparam logic [7:0] ACTIVE_BITS_MASK      = 8'h03;

   // Field positions
   localparam int  FB_HS_LSB    = 5;
   localparam int  FB_LS_TOP_W  = 4;
   localparam int  RATE_W       = 3;
   localparam int  RATE2_LSB    = 3;
   localparam int  RATE1_LSB    = 0;
   localparam int  LOSS_REF_BIT = 0;
   localparam int  LOSS_IN1_BIT = 1;
   localparam int  LOSS_IN2_BIT = 2;

   // Rate-range bands in MHz
   localparam logic [9:0] BAND0_LOW  = 10'h00A;
   localparam logic [9:0] BAND0_HIGH = 10'h01B;
   localparam logic [9:0] BAND1_LOW  = 10'h019;
   localparam logic [9:0] BAND1_HIGH = 10'h036;
   localparam logic [9:0] BAND2_LOW  = 10'h032;
   localparam logic [9:0] BAND2_HIGH = 10'h069;
   localparam logic [9:0] BAND3_LOW  = 10'h05F;
   localparam logic [9:0] BAND3_HIGH = 10'h0D7;
   localparam logic [9:0] BAND4_LOW  = 10'h0BE;
   localparam logic [9:0] BAND4_HIGH = 10'h1B3;
   localparam logic [9:0] BAND5_LOW  = 10'h177;
   localparam logic [9:0] BAND5_HIGH = 10'h2C6;
   localparam logic [2:0] RATE_LAST_VALID = 3'h5;

endpackage : dcsr_pkg

// file: rtl/dcsr_regs.sv
// Divider configuration and input status register bank.
// Assumes a byte-wide register port on the configuration clock, with
// alarms from the analog side and input selection from the switch logic.
//
// Contract
// - The feedback divider low byte is read-write and resets to F9.
// - The feedback divider ratio is the 20-bit field plus one.
// - Input divider one is 19 bits over three registers, zero = 1.
// - Input one low byte resets to 09 and its top bits to 00.
// - Input divider two is laid out like input divider one.
// - Rate ranges: bits 5:3 for input two, 2:0 for one, 7:6 reserved.
// - Rate codes 0 to 5 select bands from 10-27 up to 375-710 MHz.
// - Active bit 0 is set while input one feeds the loop.
// - Active bit 1 is set while input two feeds the loop.
// - Active status resets to 20 with upper six bits reserved.
// - Loss status bit 2 shows the live input two alarm.
// - Loss status bit 1 shows the live input one alarm.
// - Loss status bit 0 shows the live reference alarm.
// - Feedback divider bits 19:16 sit in the low nibble of its own reg.
// - Live alarms set latched flags that drive the interrupt.
`timescale 1ns/100ps
module dcsr_regs
   import dcsr_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   input  wire logic [DATA_W-1:0] regWrData,
   output logic      [DATA_W-1:0] regRdData,
   output logic                   regRdValid,
   input  wire logic              input1Selected,
   input  wire logic              input2Selected,
   input  wire logic              input1SignalLoss,
   input  wire logic              input2SignalLoss,
   input  wire logic              refclkSignalLoss,
   input  wire logic [LOSS_W-1:0] lossMask,
   input  wire logic              intPinEnable,
   output logic      [19:0]       feedbackLowSpeedDiv,
   output logic      [2:0]        feedbackHighSpeedDiv,
   output logic      [20:0]       feedbackDivRatio,
   output logic      [18:0]       input1Divider,
   output logic      [19:0]       input1DivRatio,
   output logic      [18:0]       input2Divider,
   output logic      [19:0]       input2DivRatio,
   output logic      [2:0]        input1RateRange,
   output logic      [2:0]        input2RateRange,
   output logic      [9:0]        input1BandLowMhz,
   output logic      [9:0]        input1BandHighMhz,
   output logic      [9:0]        input2BandLowMhz,
   output logic      [9:0]        input2BandHighMhz,
   output logic                   rateRangeReserved,
   output logic                   input1Active,
   output logic                   input2Active,
   output logic      [LOSS_W-1:0] signalLossLatched,
   output logic                   interruptOut
);

   typedef struct packed {
      logic [7:0]        fbHigh;
      logic [7:0]        fbMid;
      logic [7:0]        fbLow;
      logic [7:0]        in1High;
      logic [7:0]        in1Mid;
      logic [7:0]        in1Low;
      logic [7:0]        in2High;
      logic [7:0]        in2Mid;
      logic [7:0]        in2Low;
      logic [7:0]        rates;
      logic              act1;
      logic              act2;
      logic [LOSS_W-1:0] flags;
      logic [7:0]        rdData;
      logic              rdValid;
      logic              intOut;
   } dcsr_regs_s;

   dcsr_regs_s          state;
   dcsr_regs_s          next_state;
   logic [LOSS_W-1:0]   lossLive;
   logic [20:0]         in1RatioWide;
   logic [20:0]         in2RatioWide;

   // Ratio is field plus one for the feedback low-speed and both input dividers
   function automatic logic [20:0] divPlusOne(input logic [19:0] field);
      divPlusOne = {1'b0, field} + 21'h000001;
   endfunction : divPlusOne

   // Band edges in MHz for a rate code, zero for reserved codes
   function automatic logic [19:0] bandOf(input logic [2:0] code);
      case (code)
         3'h0: bandOf = {BAND0_LOW, BAND0_HIGH};
         3'h1: bandOf = {BAND1_LOW, BAND1_HIGH};
         3'h2: bandOf = {BAND2_LOW, BAND2_HIGH};
         3'h3: bandOf = {BAND3_LOW, BAND3_HIGH};
         3'h4: bandOf = {BAND4_LOW, BAND4_HIGH};
         3'h5: bandOf = {BAND5_LOW, BAND5_HIGH};
         default: bandOf = 20'h00000;
      endcase
   endfunction : bandOf

   dcsr_sync u_sync (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .alarmRaw  ({input2SignalLoss, input1SignalLoss, refclkSignalLoss}),
      .alarmSync (lossLive)
   );

   always_comb begin
      next_state = state;
      if (regWrite) begin
         case (regAddr)
            FB_DIV_HIGH_BITS_ADDR:
               next_state.fbHigh = regWrData & FB_DIV_HIGH_BITS_MASK;
            FB_DIV_MID_BYTE_ADDR: next_state.fbMid = regWrData;
            FB_DIV_LOW_BYTE_ADDR: next_state.fbLow = regWrData;
            IN1_DIV_HIGH_BITS_ADDR:
               next_state.in1High = regWrData & DIV_HIGH_BITS_MASK;
            IN1_DIV_MID_BYTE_ADDR: next_state.in1Mid = regWrData;
            IN1_DIV_LOW_BYTE_ADDR: next_state.in1Low = regWrData;
            IN2_DIV_HIGH_BITS_ADDR:
               next_state.in2High = regWrData & DIV_HIGH_BITS_MASK;
            IN2_DIV_MID_BYTE_ADDR: next_state.in2Mid = regWrData;
            IN2_DIV_LOW_BYTE_ADDR: next_state.in2Low = regWrData;
            INPUT_RATE_RANGES_ADDR:
               next_state.rates = regWrData & RATE_RANGES_MASK;
            default: ;
         endcase
      end
      // Active flags follow selection gated by live loss
      next_state.act1 = input1Selected & ~lossLive[LOSS_IN1_BIT];
      next_state.act2 = input2Selected & ~lossLive[LOSS_IN2_BIT];
      // Write of zero clears a flag, a live alarm sets it and wins
      if (regWrite && regAddr == SIGNAL_LOSS_FLAG_ADDR) begin
         next_state.flags = state.flags & regWrData[LOSS_W-1:0];
      end
      next_state.flags = next_state.flags | lossLive;
      next_state.intOut = intPinEnable
                        & |(state.flags & ~lossMask);
      next_state.rdValid = regRead;
      next_state.rdData  = 8'h00;
      if (regRead) begin
         case (regAddr)
            FB_DIV_HIGH_BITS_ADDR:  next_state.rdData = state.fbHigh;
            FB_DIV_MID_BYTE_ADDR:   next_state.rdData = state.fbMid;
            FB_DIV_LOW_BYTE_ADDR:   next_state.rdData = state.fbLow;
            IN1_DIV_HIGH_BITS_ADDR: next_state.rdData = state.in1High;
            IN1_DIV_MID_BYTE_ADDR:  next_state.rdData = state.in1Mid;
            IN1_DIV_LOW_BYTE_ADDR:  next_state.rdData = state.in1Low;
            IN2_DIV_HIGH_BITS_ADDR: next_state.rdData = state.in2High;
            IN2_DIV_MID_BYTE_ADDR:  next_state.rdData = state.in2Mid;
            IN2_DIV_LOW_BYTE_ADDR:  next_state.rdData = state.in2Low;
            INPUT_RATE_RANGES_ADDR: next_state.rdData = state.rates;
            ACTIVE_INPUT_STAT_ADDR:
               next_state.rdData = (ACTIVE_INPUT_STAT_RST & ~ACTIVE_BITS_MASK)
                                 | {6'h00, state.act2, state.act1};
            SIGNAL_LOSS_STAT_ADDR:
               next_state.rdData = SIGNAL_LOSS_STAT_RST
                                 | {5'h00, lossLive};
            SIGNAL_LOSS_FLAG_ADDR:
               next_state.rdData = {5'h00, state.flags};
            default: next_state.rdData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state.fbHigh  <= FB_DIV_HIGH_BITS_RST;
         state.fbMid   <= FB_DIV_MID_BYTE_RST;
         state.fbLow   <= FB_DIV_LOW_BYTE_RST;
         state.in1High <= IN1_DIV_HIGH_BITS_RST;
         state.in1Mid  <= IN1_DIV_MID_BYTE_RST;
         state.in1Low  <= IN1_DIV_LOW_BYTE_RST;
         state.in2High <= IN2_DIV_HIGH_BITS_RST;
         state.in2Mid  <= IN2_DIV_MID_BYTE_RST;
         state.in2Low  <= IN2_DIV_LOW_BYTE_RST;
         state.rates   <= INPUT_RATE_RANGES_RST;
         state.act1    <= ACTIVE_INPUT_STAT_RST[0];
         state.act2    <= ACTIVE_INPUT_STAT_RST[1];
         state.flags   <= SIGNAL_LOSS_FLAG_RST[LOSS_W-1:0];
         state.rdData  <= 8'h00;
         state.rdValid <= 1'b0;
         state.intOut  <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // Register fields to the divider and monitor logic
   assign feedbackLowSpeedDiv = {state.fbHigh[FB_LS_TOP_W-1:0],
                                 state.fbMid, state.fbLow};
   assign feedbackHighSpeedDiv = state.fbHigh[FB_HS_LSB +: 3];
   assign feedbackDivRatio = divPlusOne(feedbackLowSpeedDiv);
   assign input1Divider = {state.in1High[2:0], state.in1Mid, state.in1Low};
   assign input2Divider = {state.in2High[2:0], state.in2Mid, state.in2Low};
   assign in1RatioWide = divPlusOne({1'b0, input1Divider});
   assign in2RatioWide = divPlusOne({1'b0, input2Divider});
   assign input1DivRatio = in1RatioWide[19:0];
   assign input2DivRatio = in2RatioWide[19:0];
   assign input1RateRange = state.rates[RATE1_LSB +: RATE_W];
   assign input2RateRange = state.rates[RATE2_LSB +: RATE_W];
   assign {input1BandLowMhz, input1BandHighMhz} =
          bandOf(input1RateRange);
   assign {input2BandLowMhz, input2BandHighMhz} =
          bandOf(input2RateRange);
   // Flags a reserved code left by software
   assign rateRangeReserved = (input1RateRange > RATE_LAST_VALID)
                            | (input2RateRange > RATE_LAST_VALID);
   assign input1Active = state.act1;
   assign input2Active = state.act2;
   assign signalLossLatched = state.flags;
   assign interruptOut = state.intOut;
   assign regRdData    = state.rdData;
   assign regRdValid   = state.rdValid;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   sequence wrAt(logic [7:0] addr);
      regWrite && regAddr == addr;
   endsequence

   sequence rdAt(logic [7:0] addr);
      regRead && !regWrite && regAddr == addr;
   endsequence

   fb_low_write_a: assert property (
      wrAt(FB_DIV_LOW_BYTE_ADDR) |=>
         feedbackLowSpeedDiv[7:0] == $past(regWrData))
      else $error("feedback low byte not written");

   fb_ratio_a: assert property (
      feedbackDivRatio == {1'b0, state.fbHigh[3:0], state.fbMid, state.fbLow}
         + 21'h000001)
      else $error("feedback ratio is not field plus one");

   in1_top_write_a: assert property (
      wrAt(IN1_DIV_HIGH_BITS_ADDR) |=>
         input1Divider[18:16] == $past(regWrData[2:0])
         && state.in1High[7:3] == 5'h00)
      else $error("input one top bits not written");

   in2_mid_write_a: assert property (
      wrAt(IN2_DIV_MID_BYTE_ADDR) |=>
         input2Divider[15:8] == $past(regWrData))
      else $error("input two mid byte not written");

   rate_write_a: assert property (
      wrAt(INPUT_RATE_RANGES_ADDR) |=>
         input2RateRange == $past(regWrData[5:3])
         && state.rates[7:6] == 2'h0)
      else $error("rate ranges not written");

   active_one_a: assert property (
      $past(nrst) |->
         input1Active == $past(input1Selected && !lossLive[LOSS_IN1_BIT]))
      else $error("input one active bit wrong");

   active_two_a: assert property (
      $past(nrst) |->
         input2Active == $past(input2Selected && !lossLive[LOSS_IN2_BIT]))
      else $error("input two active bit wrong");

   active_read_a: assert property (
      rdAt(ACTIVE_INPUT_STAT_ADDR) |=>
         regRdValid && regRdData[7:2] == 6'h08)
      else $error("active status reserved bits wrong");

   loss_read_a: assert property (
      rdAt(SIGNAL_LOSS_STAT_ADDR) |=>
         regRdData == {5'h00, $past(lossLive)})
      else $error("loss status does not show live alarms");

   flag_hold_a: assert property (
      lossLive[LOSS_IN1_BIT] |=> signalLossLatched[LOSS_IN1_BIT])
      else $error("live alarm did not latch its flag");

   status_ro_a: assert property (
      wrAt(ACTIVE_INPUT_STAT_ADDR) |=> $stable(state.fbLow)
         && $stable(state.rates))
      else $error("write to status changed a register");

   fb_top_write_a: assert property (
      wrAt(FB_DIV_HIGH_BITS_ADDR) |=>
         feedbackLowSpeedDiv[19:16] == $past(regWrData[3:0])
         && state.fbHigh[4] == 1'b0)
      else $error("feedback top nibble not written");

   div_reset_a: assert property (
      $past(!nrst) |-> state.fbLow == FB_DIV_LOW_BYTE_RST
         && state.in1Low == IN1_DIV_LOW_BYTE_RST
         && state.in1High == IN1_DIV_HIGH_BITS_RST)
      else $error("divider reset value wrong");

   band_decode_a: assert property (
      input1RateRange == 3'h3 |->
         input1BandLowMhz == 10'h05F && input1BandHighMhz == 10'h0D7)
      else $error("rate band decode wrong");

   band_reserved_a: assert property (
      input2RateRange > RATE_LAST_VALID |->
         rateRangeReserved && input2BandHighMhz == 10'h000)
      else $error("reserved rate code not flagged");

   loss_one_a: assert property (
      rdAt(SIGNAL_LOSS_STAT_ADDR) |=>
         regRdData[LOSS_IN1_BIT] == $past(lossLive[LOSS_IN1_BIT]))
      else $error("input one loss bit wrong");

   loss_ref_a: assert property (
      rdAt(SIGNAL_LOSS_STAT_ADDR) |=>
         regRdData[LOSS_REF_BIT] == $past(lossLive[LOSS_REF_BIT]))
      else $error("reference loss bit wrong");

   flag_keep_a: assert property (
      signalLossLatched[LOSS_IN1_BIT]
         && !(regWrite && regAddr == SIGNAL_LOSS_FLAG_ADDR)
         |=> signalLossLatched[LOSS_IN1_BIT])
      else $error("latched flag dropped without a clear");

   intr_follow_a: assert property (
      $past(nrst) |-> interruptOut
         == $past(intPinEnable && |(signalLossLatched & ~lossMask)))
      else $error("interrupt does not follow flags");

   loss_stat_ro_a: assert property (
      wrAt(SIGNAL_LOSS_STAT_ADDR) |=> $stable(state.in1Low)
         && $stable(state.in2High))
      else $error("write to loss status changed a register");

endmodule : dcsr_regs

// file: rtl/dcsr_sync.sv
// Two-stage synchroniser for the live loss-of-signal alarms.
// Assumes alarms arrive asynchronously from the analog monitors.
`timescale 1ns/100ps
module dcsr_sync
   import dcsr_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   input  wire logic [LOSS_W-1:0] alarmRaw,
   output logic      [LOSS_W-1:0] alarmSync
);

   typedef struct packed {
      logic [LOSS_W-1:0] stage1;
      logic [LOSS_W-1:0] stage2;
   } dcsr_sync_s;

   dcsr_sync_s state;
   dcsr_sync_s next_state;

   always_comb begin
      next_state.stage1 = alarmRaw;
      next_state.stage2 = state.stage1;
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign alarmSync = state.stage2;

endmodule : dcsr_sync

// file: tb/divider_config_status_regs_bench.sv
// Self-checking bench for the divider configuration and status registers.
// Assumes dcsr_regs is the top and drives every port from this module.
`timescale 1ns/100ps
module divider_config_status_regs_bench;
   import dcsr_pkg::*;

   logic              clk_sys;
   logic              nrst;
   logic [7:0]        regAddr;
   logic              regWrite;
   logic              regRead;
   logic [7:0]        regWrData;
   logic [7:0]        regRdData;
   logic              regRdValid;
   logic              sel1;
   logic              sel2;
   logic [2:0]        lossPins;
   logic [2:0]        lossMask;
   logic              intPinEnable;
   logic [19:0]       fbDiv;
   logic [2:0]        fbHs;
   logic [20:0]       fbRatio;
   logic [18:0]       in1Div;
   logic [19:0]       in1Ratio;
   logic [18:0]       in2Div;
   logic [19:0]       in2Ratio;
   logic [2:0]        rate1;
   logic [2:0]        rate2;
   logic [9:0]        lo1;
   logic [9:0]        hi1;
   logic [9:0]        lo2;
   logic [9:0]        hi2;
   logic              rateRsvd;
   logic              act1;
   logic              act2;
   logic [2:0]        flagsOut;
   logic              irq;
   logic [7:0]        mdl [0:255];
   logic [2:0]        mFlags;
   logic [7:0]        rwAddr [$] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C,
                                     8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h37};
   logic [7:0]        rwMask [$] = '{8'hEF, 8'hFF, 8'hFF, 8'h07, 8'hFF,
                                     8'hFF, 8'h07, 8'hFF, 8'hFF, 8'h3F};
   logic [7:0]        rdList [$] = '{8'h80, 8'h81, 8'h83, 8'h50, 8'hFF};
   int                bandLo [0:7] = '{10, 25, 50, 95, 190, 375, 0, 0};
   int                bandHi [0:7] = '{27, 54, 105, 215, 435, 710, 0, 0};
   int                miscompares = 0;
   int                totalChecks = 0;
   int                cycles = 0;
   int                seed = 32'h81B5;
   int                idx;

   dcsr_regs u_dcsr_regs (
      .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData),
      .regRdData(regRdData), .regRdValid(regRdValid),
      .input1Selected(sel1), .input2Selected(sel2),
      .input1SignalLoss(lossPins[1]), .input2SignalLoss(lossPins[2]),
      .refclkSignalLoss(lossPins[0]), .lossMask(lossMask),
      .intPinEnable(intPinEnable), .feedbackLowSpeedDiv(fbDiv),
      .feedbackHighSpeedDiv(fbHs), .feedbackDivRatio(fbRatio),
      .input1Divider(in1Div), .input1DivRatio(in1Ratio),
      .input2Divider(in2Div), .input2DivRatio(in2Ratio),
      .input1RateRange(rate1), .input2RateRange(rate2),
      .input1BandLowMhz(lo1), .input1BandHighMhz(hi1),
      .input2BandLowMhz(lo2), .input2BandHighMhz(hi2),
      .rateRangeReserved(rateRsvd), .input1Active(act1),
      .input2Active(act2), .signalLossLatched(flagsOut),
      .interruptOut(irq)
   );

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         endOfTest();
      end
   end

   task automatic endOfTest();
      $display("checks %0d, mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : endOfTest

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %0h, expected %0h",
                  $time, seen, exp);
      end
   endtask : chk

   task automatic mdlReset();
      foreach (mdl[i]) mdl[i] = 8'h00;
      mdl[8'h28] = 8'hC0;
      mdl[8'h2A] = 8'hF9;
      mdl[8'h2D] = 8'h09;
      mFlags = 3'h0;
   endtask : mdlReset

   function automatic logic [7:0] expRead(input logic [7:0] a);
      case (a)
         8'h80:   expRead = {6'h08, sel2 & ~lossPins[2], sel1 & ~lossPins[1]};
         8'h81:   expRead = {5'h00, lossPins};
         8'h83:   expRead = {5'h00, mFlags};
         default: expRead = mdl[a];
      endcase
   endfunction : expRead

   // Register write; entered and left just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(posedge clk_sys);
      #1;
      regWrite = 1'b0;
      foreach (rwAddr[i]) if (rwAddr[i] == a) mdl[a] = d & rwMask[i];
      if (a == 8'h83) mFlags = (mFlags & d[2:0]) | lossPins;
      @(posedge clk_sys);
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      regAddr = a;
      regRead = 1'b1;
      @(posedge clk_sys);
      #1;
      regRead = 1'b0;
      chk(regRdValid, 1'b1);
      chk(regRdData, expRead(a));
      @(posedge clk_sys);
      #1;
      chk(regRdValid, 1'b0);
      chk(regRdData, 8'h00);
   endtask : rd

   task automatic chkOut();
      logic [19:0] fb;
      logic [18:0] d1;
      logic [18:0] d2;
      int          r1;
      int          r2;
      fb = {mdl[8'h28][3:0], mdl[8'h29], mdl[8'h2A]};
      d1 = {mdl[8'h2B][2:0], mdl[8'h2C], mdl[8'h2D]};
      d2 = {mdl[8'h2E][2:0], mdl[8'h2F], mdl[8'h30]};
      r1 = mdl[8'h37][2:0];
      r2 = mdl[8'h37][5:3];
      chk(fbDiv, fb);
      chk(fbHs, mdl[8'h28][7:5]);
      chk(fbRatio, fb + 21'h1);
      chk(in1Div, d1);
      chk(in1Ratio, d1 + 20'h1);
      chk(in2Div, d2);
      chk(in2Ratio, d2 + 20'h1);
      chk({rate2, rate1}, mdl[8'h37][5:0]);
      chk(lo1, bandLo[r1]);
      chk(hi1, bandHi[r1]);
      chk(lo2, bandLo[r2]);
      chk(hi2, bandHi[r2]);
      chk(rateRsvd, (r1 > 5) || (r2 > 5));
   endtask : chkOut

   task automatic chkSt();
      chk(act1, sel1 & ~lossPins[1]);
      chk(act2, sel2 & ~lossPins[2]);
      chk(flagsOut, mFlags);
      chk(irq, intPinEnable & |(mFlags & ~lossMask));
      rd(8'h80);
      rd(8'h81);
      rd(8'h83);
   endtask : chkSt

   task automatic readAll();
      foreach (rwAddr[i]) rd(rwAddr[i]);
      foreach (rdList[i]) rd(rdList[i]);
      chkOut();
   endtask : readAll

   initial begin
      nrst = 1'b0;
      regAddr = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWrData = 8'h00;
      {sel1, sel2, lossPins, lossMask, intPinEnable} = '0;
      mdlReset();
      repeat (5) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      @(posedge clk_sys);
      #1;
      readAll();
      // Random traffic on the writable registers
      repeat (60) begin
         idx = {$random(seed)} % rwAddr.size();
         wr(rwAddr[idx], $random(seed));
         rd(rwAddr[idx]);
         chkOut();
      end
      // Status registers and unmapped places ignore writes
      foreach (rdList[i]) wr(rdList[i], 8'hFF);
      readAll();
      // Every rate code on both inputs, reserved ones too
      for (int c = 0; c < 8; c++) begin
         wr(8'h37, {2'h3, 3'(c), 3'(7 - c)});
         rd(8'h37);
         chkOut();
      end
      // Alarms, active inputs, latched flags and the interrupt
      intPinEnable = 1'b1;
      sel1 = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      chkSt();
      for (int b = 0; b < 3; b++) begin
         lossPins[b] = 1'b1;
         mFlags[b] = 1'b1;
         repeat (6) @(posedge clk_sys);
         #1;
         chkSt();
         wr(8'h83, 8'h00);
         chkSt();
         lossMask = 3'(1 << b);
         @(posedge clk_sys);
         #1;
         chkSt();
         lossMask = 3'h0;
         lossPins[b] = 1'b0;
         repeat (6) @(posedge clk_sys);
         #1;
         chkSt();
         wr(8'h83, 8'h00);
         chkSt();
         {sel2, sel1} = (b == 1) ? 2'h2 : 2'h1;
      end
      intPinEnable = 1'b0;
      lossPins = 3'h5;
      mFlags = 3'h5;
      repeat (6) @(posedge clk_sys);
      #1;
      chkSt();
      lossPins = 3'h0;
      // Reset in mid-run returns the reset values
      nrst = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      mdlReset();
      sel1 = 1'b0;
      sel2 = 1'b0;
      @(posedge clk_sys);
      #1;
      readAll();
      endOfTest();
   end

endmodule : divider_config_status_regs_bench
